/* design/swl_top.sv */
// Synthesiser word, tone spacing, reference divider and lock register bank on APB
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.svh"

module swl_top #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] synth_word_one_upper,
   input wire logic ref_clk_in,
   input wire logic lock_window_in,
   input wire logic tune_high_in,
   input wire logic tune_low_in,
   output logic [23:0] synth_word_active,
   output logic [10:0] tone_spacing_word,
   output logic [4:0] ref_divider_ratio,
   output logic lock_window_len,
   output logic phase_match_locked
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------

   // Printed offsets are word indices; byte address is index times four
   function automatic swl_pkg::swl_sel_t swl_decode(
      input logic [ADDR_W-1:0] addr
   );
      swl_pkg::swl_sel_t sel;
      sel = swl_pkg::SWL_SEL_NONE;
      if (addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == '0) begin
         unique case (addr[9:2])
            `SWL_IDX_MAIN_CTRL: begin
               sel = swl_pkg::SWL_SEL_MAIN;
            end
            `SWL_IDX_WORD_ONE_LOW: begin
               sel = swl_pkg::SWL_SEL_W1_LOW;
            end
            `SWL_IDX_WORD_TWO_LOW: begin
               sel = swl_pkg::SWL_SEL_W2_LOW;
            end
            `SWL_IDX_WORD_TWO_MID: begin
               sel = swl_pkg::SWL_SEL_W2_MID;
            end
            `SWL_IDX_WORD_TWO_HIGH: begin
               sel = swl_pkg::SWL_SEL_W2_HIGH;
            end
            `SWL_IDX_PLL_CTRL: begin
               sel = swl_pkg::SWL_SEL_PLL;
            end
            `SWL_IDX_LOCK: begin
               sel = swl_pkg::SWL_SEL_LOCK;
            end
            `SWL_IDX_SPACING_LOW: begin
               sel = swl_pkg::SWL_SEL_SP_LOW;
            end
            `SWL_IDX_SPACING_HIGH: begin
               sel = swl_pkg::SWL_SEL_SP_HIGH;
            end
            default: begin
               sel = swl_pkg::SWL_SEL_NONE;
            end
         endcase
      end
      return sel;
   endfunction

   // ------------------------------------------------------------
   // State and combinational helpers
   // ------------------------------------------------------------

   swl_pkg::swl_state_t st;
   swl_pkg::swl_state_t next_st;
   swl_pkg::swl_sel_t sel;
   logic setup;
   logic wr_take;
   logic ref_edge;
   logic filt_locked;
   logic [7:0] rd_byte;

   // ------------------------------------------------------------
   // Filtered lock detector
   // ------------------------------------------------------------

   swl_lock_filter #(
      .CNT_W(7)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .sample_stb(ref_edge),
      .in_window(st.win_sync[1]),
      .strict(st.lock_strict),
      .locked(filt_locked)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------

   always_comb begin
      next_st = st;
      sel = swl_decode(paddr);
      setup = psel & ~penable;
      // Writes land only at the edge where the access phase completes
      wr_take = psel & penable & st.pready & pwrite & pstrb[0];
      ref_edge = st.ref_sync[1] & ~st.ref_prev;
      rd_byte = 8'h00;

      // Pins from the analog side are synchronised before use
      next_st.ref_sync = {st.ref_sync[0], ref_clk_in};
      next_st.ref_prev = st.ref_sync[1];
      next_st.win_sync = {st.win_sync[0], lock_window_in};
      next_st.hi_sync = {st.hi_sync[0], tune_high_in};
      next_st.lo_sync = {st.lo_sync[0], tune_low_in};

      // One window sample per rising edge of the reference clock
      if (ref_edge) begin
         next_st.instant = st.win_sync[1];
      end

      // Disabled alarms are held at zero rather than frozen
      next_st.alarm_hi = st.alarm_dis ? 1'b0 : st.hi_sync[1];
      next_st.alarm_lo = st.alarm_dis ? 1'b0 : st.lo_sync[1];

      // Read mux
      unique case (sel)
         swl_pkg::SWL_SEL_MAIN: begin
            rd_byte = {7'h00, st.word_sel};
         end
         swl_pkg::SWL_SEL_W1_LOW: begin
            rd_byte = st.w1_low;
         end
         swl_pkg::SWL_SEL_W2_LOW: begin
            rd_byte = st.w2_low;
         end
         swl_pkg::SWL_SEL_W2_MID: begin
            rd_byte = st.w2_mid;
         end
         swl_pkg::SWL_SEL_W2_HIGH: begin
            rd_byte = st.w2_high;
         end
         swl_pkg::SWL_SEL_PLL: begin
            // Gated here as well: the alarm register lags a fresh disable by one cycle
            rd_byte = {st.ref_div, st.alarm_dis, st.alarm_hi & ~st.alarm_dis, st.alarm_lo & ~st.alarm_dis};
         end
         swl_pkg::SWL_SEL_LOCK: begin
            rd_byte = {4'h0, st.lock_strict, st.lock_len, st.instant, filt_locked};
         end
         swl_pkg::SWL_SEL_SP_LOW: begin
            rd_byte = st.spacing[7:0];
         end
         swl_pkg::SWL_SEL_SP_HIGH: begin
            rd_byte = {5'h00, st.spacing[10:8]};
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase

      // Zero-wait slave: ready is raised for the first access cycle
      next_st.pready = setup;
      next_st.pslverr = setup & (sel == swl_pkg::SWL_SEL_NONE);
      if (setup) begin
         next_st.prdata = {24'h000000, rd_byte};
      end

      if (wr_take) begin
         unique case (sel)
            swl_pkg::SWL_SEL_MAIN: begin
               next_st.word_sel = pwdata[`SWL_MAIN_SEL_BIT];
            end
            swl_pkg::SWL_SEL_W1_LOW: begin
               next_st.w1_low = pwdata[7:0];
            end
            swl_pkg::SWL_SEL_W2_LOW: begin
               next_st.w2_low = pwdata[7:0];
            end
            swl_pkg::SWL_SEL_W2_MID: begin
               next_st.w2_mid = pwdata[7:0];
            end
            swl_pkg::SWL_SEL_W2_HIGH: begin
               // Values below 0x40 are stored as written; the PLL just misbehaves
               next_st.w2_high = pwdata[7:0];
            end
            swl_pkg::SWL_SEL_PLL: begin
               // Divider outside 2..24 is not trapped here
               next_st.ref_div = pwdata[`SWL_PLL_DIV_MSB:`SWL_PLL_DIV_LSB];
               next_st.alarm_dis = pwdata[`SWL_PLL_ALARM_DIS_BIT];
            end
            swl_pkg::SWL_SEL_LOCK: begin
               next_st.lock_strict = pwdata[`SWL_LOCK_STRICT_BIT];
               next_st.lock_len = pwdata[`SWL_LOCK_LEN_BIT];
            end
            swl_pkg::SWL_SEL_SP_LOW: begin
               next_st.spacing[7:0] = pwdata[7:0];
            end
            swl_pkg::SWL_SEL_SP_HIGH: begin
               next_st.spacing[10:8] = pwdata[`SWL_SPACING_HIGH_MSB:0];
            end
            default: begin
               next_st.word_sel = st.word_sel;
            end
         endcase
      end

      // Active word follows the select bit one cycle after any change
      if (st.word_sel) begin
         next_st.word_out = {st.w2_high, st.w2_mid, st.w2_low};
      end else begin
         next_st.word_out = {synth_word_one_upper, st.w1_low};
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.w1_low <= `SWL_RST_WORD_ONE_LOW;
         st.w2_low <= `SWL_RST_WORD_TWO_LOW;
         st.w2_mid <= `SWL_RST_WORD_TWO_MID;
         st.w2_high <= `SWL_RST_WORD_TWO_HIGH;
         st.spacing <= `SWL_RST_SPACING;
         st.ref_div <= `SWL_RST_REF_DIV;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign synth_word_active = st.word_out;
   assign tone_spacing_word = st.spacing;
   assign ref_divider_ratio = st.ref_div;
   assign lock_window_len = st.lock_len;
   assign phase_match_locked = filt_locked;

endmodule
`default_nettype wire

/* design/swl_regs.svh */
// Register indices, field positions and reset values of the synthesiser word and lock bank
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH

`define SWL_IDX_MAIN_CTRL 8'hc8
`define SWL_IDX_WORD_ONE_LOW 8'hca
`define SWL_IDX_WORD_TWO_LOW 8'hcd
`define SWL_IDX_WORD_TWO_MID 8'hce
`define SWL_IDX_WORD_TWO_HIGH 8'hcf
`define SWL_IDX_PLL_CTRL 8'he3
`define SWL_IDX_LOCK 8'he4
`define SWL_IDX_SPACING_LOW 8'hea
`define SWL_IDX_SPACING_HIGH 8'heb

`define SWL_RST_WORD_ONE_LOW 8'hcb
`define SWL_RST_WORD_TWO_LOW 8'h4e
`define SWL_RST_WORD_TWO_MID 8'ha5
`define SWL_RST_WORD_TWO_HIGH 8'h75
`define SWL_RST_SPACING 11'h059
`define SWL_RST_REF_DIV 5'h02

`define SWL_MAIN_SEL_BIT 0
`define SWL_PLL_DIV_MSB 7
`define SWL_PLL_DIV_LSB 3
`define SWL_PLL_ALARM_DIS_BIT 2
`define SWL_SPACING_HIGH_MSB 2
`define SWL_LOCK_STRICT_BIT 3
`define SWL_LOCK_LEN_BIT 2

`define SWL_THR_SET_NORMAL 7'h7f
`define SWL_THR_CLR_NORMAL 7'h6f
`define SWL_THR_SET_STRICT 7'h1f
`define SWL_THR_CLR_STRICT 7'h0f

`endif

/* design/swl_pkg.sv */
// Types shared by the synthesiser word and lock bank
package swl_pkg;

   typedef enum logic [3:0] {
      SWL_SEL_NONE,
      SWL_SEL_MAIN,
      SWL_SEL_W1_LOW,
      SWL_SEL_W2_LOW,
      SWL_SEL_W2_MID,
      SWL_SEL_W2_HIGH,
      SWL_SEL_PLL,
      SWL_SEL_LOCK,
      SWL_SEL_SP_LOW,
      SWL_SEL_SP_HIGH
   } swl_sel_t;

   typedef struct packed {
      logic [6:0] count;
      logic locked;
   } swl_filt_state_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic word_sel;
      logic [7:0] w1_low;
      logic [7:0] w2_low;
      logic [7:0] w2_mid;
      logic [7:0] w2_high;
      logic [10:0] spacing;
      logic [4:0] ref_div;
      logic alarm_dis;
      logic lock_strict;
      logic lock_len;
      logic [1:0] ref_sync;
      logic ref_prev;
      logic [1:0] win_sync;
      logic [1:0] hi_sync;
      logic [1:0] lo_sync;
      logic instant;
      logic alarm_hi;
      logic alarm_lo;
      logic [23:0] word_out;
   } swl_state_t;

endpackage

/* design/swl_lock_filter.sv */
// Filtered lock detector: saturating count of in-window reference samples
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.svh"

module swl_lock_filter #(
   parameter int CNT_W = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample_stb,
   input wire logic in_window,
   input wire logic strict,
   output logic locked
);

   swl_pkg::swl_filt_state_t st;
   swl_pkg::swl_filt_state_t next_st;
   logic [CNT_W-1:0] set_thr;
   logic [CNT_W-1:0] clr_thr;

   always_comb begin
      next_st = st;
      set_thr = strict ? CNT_W'(`SWL_THR_SET_STRICT) : CNT_W'(`SWL_THR_SET_NORMAL);
      clr_thr = strict ? CNT_W'(`SWL_THR_CLR_STRICT) : CNT_W'(`SWL_THR_CLR_NORMAL);
      if (sample_stb) begin
         // Count saturates at both ends so a long run never wraps
         if (in_window) begin
            if (st.count != {CNT_W{1'b1}}) begin
               next_st.count = st.count + 1'b1;
            end
         end else begin
            if (st.count != '0) begin
               next_st.count = st.count - 1'b1;
            end
         end
      end
      // Hysteresis between the two thresholds keeps the flag from chattering
      if (next_st.count >= set_thr) begin
         next_st.locked = 1'b1;
      end else if (next_st.count <= clr_thr) begin
         next_st.locked = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign locked = st.locked;

endmodule
`default_nettype wire

/* verif/swl_assertions.sv */
// Port checker for the synthesiser word and lock register bank
`timescale 1ns/1ps
`default_nettype none
module swl_assertions #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [10:0] tone_spacing_word,
   input wire logic [4:0] ref_divider_ratio,
   input wire logic phase_match_locked
);
   logic acc;
   logic wr;
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite & pstrb[0];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_bad_addr;
      psel && !penable && paddr == 12'h000 |=> pslverr && pready;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");
   property p_sp_high_zero;
      acc && !pwrite && paddr == 12'h3ac |-> prdata[7:3] == 5'h00;
   endproperty
   a_sp_high_zero: assert property (p_sp_high_zero) else $error("spacing upper bits not zero");
   property p_lock_read;
      acc && !pwrite && paddr == 12'h390 |-> prdata[7:4] == 4'h0 && prdata[0] == $past(phase_match_locked);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock register read wrong");
   property p_div_write;
      wr && paddr == 12'h38c |=> ##1 ref_divider_ratio == $past(pwdata[7:3], 2);
   endproperty
   a_div_write: assert property (p_div_write) else $error("divider not taken");
   property p_sp_low_write;
      wr && paddr == 12'h3a8 |=> ##1 tone_spacing_word[7:0] == $past(pwdata[7:0], 2);
   endproperty
   a_sp_low_write: assert property (p_sp_low_write) else $error("spacing low not taken");
   property p_sp_high_write;
      wr && paddr == 12'h3ac |=> ##1 tone_spacing_word[10:8] == $past(pwdata[2:0], 2);
   endproperty
   a_sp_high_write: assert property (p_sp_high_write) else $error("spacing high not taken");
   property p_alarm_off;
      acc && !pwrite && paddr == 12'h38c && prdata[2] |-> prdata[1:0] == 2'b00;
   endproperty
   a_alarm_off: assert property (p_alarm_off) else $error("alarm seen while disabled");
   c_lock_set: cover property ($rose(phase_match_locked));
   c_err: cover property (pslverr);
   c_div_write: cover property (wr && paddr == 12'h38c);
endmodule
bind swl_top swl_assertions #(.ADDR_W(ADDR_W)) swl_assertions_inst (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .tone_spacing_word(tone_spacing_word),
   .ref_divider_ratio(ref_divider_ratio),
   .phase_match_locked(phase_match_locked)
);
`default_nettype wire

/* verif/synth_word_lock_regs_bench.sv */
// Self-checking bench for the synthesiser word and lock register bank
`timescale 1ns/1ps
`default_nettype none
module synth_word_lock_regs_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic ref_clk_in = 0, lock_window_in = 0, tune_high_in = 0, tune_low_in = 0;
   logic [15:0] synth_word_one_upper = 16'h0000;
   logic [23:0] synth_word_active;
   logic [10:0] tone_spacing_word;
   logic [4:0] ref_divider_ratio;
   logic lock_window_len, phase_match_locked, er, lk = 0, strict = 0;
   logic [7:0] d;
   integer seed = 3;
   int err_total = 0, n_checks = 0, cyc = 0, cnt = 0, i;
   logic [11:0] ad [9] = '{12'h328, 12'h334, 12'h338, 12'h33c, 12'h3a8, 12'h3ac, 12'h38c, 12'h390, 12'h320};
   logic [7:0] rv [9] = '{8'hcb, 8'h4e, 8'ha5, 8'h75, 8'h59, 8'h00, 8'h10, 8'h00, 8'h00};
   logic [7:0] wm [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'hfc, 8'h0c, 8'h01};
   logic [7:0] mv [9];
   always #12.5 pclk = ~pclk;
   swl_top swl_top_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .synth_word_one_upper(synth_word_one_upper),
      .ref_clk_in(ref_clk_in),
      .lock_window_in(lock_window_in),
      .tune_high_in(tune_high_in),
      .tune_low_in(tune_low_in),
      .synth_word_active(synth_word_active),
      .tone_spacing_word(tone_spacing_word),
      .ref_divider_ratio(ref_divider_ratio),
      .lock_window_len(lock_window_len),
      .phase_match_locked(phase_match_locked)
   );
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic win(input logic v);
      lock_window_in <= v;
      repeat (4) @(posedge pclk);
   endtask
   // Reference pulses; the filter model advances once per rising edge
   task automatic pulse(input int n);
      repeat (n) begin
         ref_clk_in <= 1'b1;
         repeat (4) @(posedge pclk);
         ref_clk_in <= 1'b0;
         repeat (4) @(posedge pclk);
         cnt = lock_window_in ? (cnt < 127 ? cnt + 1 : 127) : (cnt > 0 ? cnt - 1 : 0);
         if (cnt >= (strict ? 31 : 127)) lk = 1;
         else if (cnt <= (strict ? 15 : 111)) lk = 0;
         chk("locked", {31'h0, lk}, {31'h0, phase_match_locked});
      end
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test;
      end
   end
   initial begin
      synth_word_one_upper <= 16'($random(seed)) | 16'h4000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 9; i++) begin
         apb(0, ad[i], 8'h00, 4'hf);
         chk("reset value", {24'h0, rv[i]}, rd);
      end
      $display("reset values done");
      for (i = 0; i < 9; i++) begin
         d = 8'($random(seed));
         if (i == 3) d[6] = 1'b1;
         if (i == 6) d[7:3] = 5'd2 + 5'(($random(seed) & 32'hff) % 23);
         if (i == 7) d[2] = 1'b0;
         apb(1, ad[i], d, 4'hf);
         mv[i] = d & wm[i];
      end
      apb(1, ad[0], ~mv[0], 4'h0);
      for (i = 0; i < 9; i++) begin
         apb(0, ad[i], 8'h00, 4'hf);
         chk("read back", {24'h0, mv[i]}, rd);
      end
      chk("divider", {27'h0, mv[6][7:3]}, {27'h0, ref_divider_ratio});
      chk("spacing", {21'h0, mv[5][2:0], mv[4]}, {21'h0, tone_spacing_word});
      chk("window len", 32'h0, {31'h0, lock_window_len});
      $display("write and read done");
      apb(1, 12'h000, 8'hff, 4'hf);
      chk("slverr", 32'h1, {31'h0, er});
      apb(0, 12'h329, 8'h00, 4'hf);
      chk("slverr", 32'h1, {31'h0, er});
      chk("bad read", 32'h0, rd);
      $display("unmapped done");
      for (i = 1; i >= 0; i--) begin
         apb(1, 12'h320, 8'(i), 4'hf);
         repeat (3) @(posedge pclk);
         chk("active word", i ? {8'h0, mv[3], mv[2], mv[1]} : {8'h0, synth_word_one_upper, mv[0]},
            {8'h0, synth_word_active});
      end
      $display("word select done");
      for (i = 0; i < 4; i++) begin
         apb(1, 12'h38c, {mv[6][7:3], i[1], 2'b00}, 4'hf);
         tune_high_in <= i[0];
         tune_low_in <= ~i[0];
         repeat (6) @(posedge pclk);
         apb(0, 12'h38c, 8'h00, 4'hf);
         chk("alarms", {24'h0, mv[6][7:3], i[1], i[1] ? 2'b00 : {i[0], ~i[0]}}, rd);
      end
      $display("alarms done");
      apb(1, 12'h390, 8'h08, 4'hf);
      strict = 1;
      win(1);
      pulse(35);
      apb(0, 12'h390, 8'h00, 4'hf);
      chk("lock reg", 32'h0b, rd);
      win(0);
      pulse(25);
      apb(1, 12'h390, 8'h00, 4'hf);
      strict = 0;
      win(1);
      pulse(120);
      win(0);
      pulse(20);
      $display("lock filter done");
      stop_test;
   end
endmodule
`default_nettype wire
